// >>> src/rx_char_mem.sv
// receive character memory with registered read port
`timescale 1ns/100ps
`default_nettype none
`include "uart_status_cfg.svh"

module rx_char_mem
    import uart_status_pkg::*;
(
    // clocking
    input wire logic hclk,
    input wire logic ce,
    // access port
    rx_mem_if.mem mp
);

    rx_entry_t store_r [`RXF_DEPTH]; // character slots
    rx_entry_t rd_data_r; // read data register

    // write and registered read, both frozen by the clock enable
    always_ff @(posedge hclk)
    begin
        if (ce)
        begin
            if (mp.wr_en)
            begin
                store_r[mp.wr_addr] <= mp.wr_data;
            end
            rd_data_r <= store_r[mp.rd_addr];
        end
    end

    assign mp.rd_data = rd_data_r;

endmodule

`default_nettype wire

// >>> src/rx_mem_if.sv
// port bundle between the status logic and the receive character memory
`timescale 1ns/100ps
`default_nettype none
`include "uart_status_cfg.svh"

interface rx_mem_if;
    import uart_status_pkg::*;

    logic wr_en; // store one entry
    logic [`RXF_AW-1:0] wr_addr; // write slot
    rx_entry_t wr_data; // entry to store
    logic [`RXF_AW-1:0] rd_addr; // slot presented next cycle
    rx_entry_t rd_data; // registered read data

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// >>> src/uart_line_modem_status.sv
// line and modem status logic of one uart channel with an ahb-lite register slave
// Functional notes
// - parity flag follows character at fifo top
// - overrun flag when char arrives, fifo full
// - overrunning byte dropped, stored characters kept
// - data ready while any character held
// - parity, overrun, data ready zero after reset
// - modem status read, extra-feature control write
// - reading modem status clears four change flags
// - carrier bit: inverted input or output two
// - ring bit: inverted input or output one
// - dsr bit: inverted input or dtr bit
// - cts bit: inverted input or rts bit
// - cd, dsr, cts flags on any change
// - ring flag only on input low-to-high
// - any change flag raises modem interrupt
`timescale 1ns/100ps
`default_nettype none
`include "uart_status_cfg.svh"

module uart_line_modem_status
    import uart_status_pkg::*;
(
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output var logic [31:0] hrdata,
    output var logic hreadyout,
    output var logic hresp,
    // received characters from the deserialiser
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_parity_bad,
    // modem inputs, active low
    input wire logic cd_n,
    input wire logic ri_n,
    input wire logic dsr_n,
    input wire logic cts_n,
    // control outputs
    output var logic [`MC_WIDTH-1:0] modem_ctrl,
    output var logic [7:0] extra_ctrl,
    output var logic irq
);

    // address decode, shared by read and write paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // bus slave state
    bus_state_t state_r; // current phase
    logic [7:0] addr_r; // latched address
    logic write_r; // latched direction
    logic [31:0] hrdata_r; // read data register
    logic hreadyout_r; // ready register
    logic hresp_r; // response register, always okay

    // software registers
    logic [`MC_WIDTH-1:0] modem_ctrl_r; // modem_output_control
    logic [7:0] extra_ctrl_r; // extra_feature_control
    logic fifo_en_r; // fifo mode
    logic [`IRQ_WIDTH-1:0] irq_status_r; // sticky events
    logic [`IRQ_WIDTH-1:0] irq_mask_r; // enables
    logic irq_r; // interrupt output register

    // receive storage state
    logic [`RXF_AW-1:0] wr_ptr_r; // next write slot
    logic [`RXF_AW-1:0] rd_ptr_r; // top slot
    logic [`RXF_AW:0] count_r; // characters held
    logic overrun_r; // overrun flag

    // modem state
    logic [3:0] pin_meta_r; // first sync stage
    logic [3:0] pin_sync_r; // second sync stage
    logic [3:0] live_prev_r; // live bits one cycle ago
    logic [3:0] delta_r; // change flags

    rx_mem_if mem_bus ();

    // bus phase decode
    wire logic take = ce & hsel & hready & htrans[1] & (state_r == ST_ADDR);
    wire logic acc = ce & (state_r == ST_DATA);
    wire logic do_rd = acc & ~write_r;
    wire logic do_wr = acc & write_r;
    wire logic [7:0] wbyte = hwdata[7:0];

    // next bus phase: a taken address phase is always followed by one data phase
    bus_state_t state_nxt;
    always_comb
    begin
        case (state_r)
            ST_ADDR: state_nxt = take ? ST_DATA : ST_ADDR;
            ST_DATA: state_nxt = ce ? ST_ADDR : ST_DATA;
            default: state_nxt = ST_ADDR;
        endcase
    end

    // per-register strobes
    wire logic rd_rx = do_rd & hit(addr_r, `OFF_RX_DATA);
    wire logic rd_line = do_rd & hit(addr_r, `OFF_LINE_STATUS);
    wire logic rd_modem = do_rd & hit(addr_r, `OFF_MODEM_STATUS);
    wire logic wr_extra = do_wr & hit(addr_r, `OFF_MODEM_STATUS);
    wire logic wr_mctrl = do_wr & hit(addr_r, `OFF_MODEM_CTRL);
    wire logic wr_fctrl = do_wr & hit(addr_r, `OFF_FIFO_CTRL);
    wire logic wr_istat = do_wr & hit(addr_r, `OFF_IRQ_STATUS);
    wire logic wr_imask = do_wr & hit(addr_r, `OFF_IRQ_MASK);

    // receive storage decode
    wire logic [`RXF_AW:0] cap = fifo_en_r ? (`RXF_AW+1)'(`RXF_DEPTH) : (`RXF_AW+1)'(1);
    wire logic not_empty = (count_r != '0);
    wire logic full = (count_r >= cap);
    wire logic push = ce & rx_valid & ~full;
    wire logic over = ce & rx_valid & full;
    wire logic pop = rd_rx & not_empty;
    wire logic flush = wr_fctrl;
    wire logic head_parity = not_empty & mem_bus.rd_data.parity_bad;

    // line_status image
    wire logic [7:0] line_img = {5'h00, head_parity, overrun_r, not_empty};

    // modem live bits: loopback takes modem_output_control bits
    wire logic loop = modem_ctrl_r[`MC_LOOP];
    wire logic [3:0] loop_src = {modem_ctrl_r[`MC_OUT_TWO], modem_ctrl_r[`MC_OUT_ONE],
                                 modem_ctrl_r[`MC_DTR], modem_ctrl_r[`MC_RTS]};
    wire logic [3:0] live = loop ? loop_src : ~pin_sync_r;
    wire logic [3:0] delta_set;
    wire logic [7:0] modem_img = {live, delta_r};

    // read data selection
    wire logic [7:0] rd_byte =
        hit(addr_r, `OFF_RX_DATA) ? mem_bus.rd_data.data :
        hit(addr_r, `OFF_LINE_STATUS) ? line_img :
        hit(addr_r, `OFF_MODEM_STATUS) ? modem_img :
        hit(addr_r, `OFF_MODEM_CTRL) ? {3'h0, modem_ctrl_r} :
        hit(addr_r, `OFF_FIFO_CTRL) ? {7'h00, fifo_en_r} :
        hit(addr_r, `OFF_IRQ_STATUS) ? {4'h0, irq_status_r} :
        hit(addr_r, `OFF_IRQ_MASK) ? {4'h0, irq_mask_r} : 8'h00;

    // interrupt events
    wire logic [`IRQ_WIDTH-1:0] irq_evt = {push, push & rx_parity_bad, over, |delta_r};
    wire logic [`IRQ_WIDTH-1:0] irq_clr = wr_istat ? wbyte[`IRQ_WIDTH-1:0] : '0;
    wire logic [`IRQ_WIDTH-1:0] irq_status_nxt = (irq_status_r & ~irq_clr) | irq_evt;

    // memory port wiring
    assign mem_bus.wr_en = push & ~flush;
    assign mem_bus.wr_addr = wr_ptr_r;
    assign mem_bus.wr_data = '{parity_bad: rx_parity_bad, data: rx_data};
    assign mem_bus.rd_addr = rd_ptr_r;

    // receive character memory
    rx_char_mem u_mem (
        .hclk(hclk),
        .ce(ce),
        .mp(mem_bus)
    );

    // bus slave phases: one wait state per transfer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= ST_ADDR;
            addr_r <= 8'h00;
            write_r <= 1'b0;
            hreadyout_r <= 1'b1;
        end
        else if (take)
        begin
            state_r <= state_nxt;
            addr_r <= haddr[7:0];
            write_r <= hwrite;
            hreadyout_r <= 1'b0;
        end
        else if (acc)
        begin
            state_r <= state_nxt;
            hreadyout_r <= 1'b1;
        end
    end

    // read data register, zero for writes and unmapped addresses
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_r <= 32'h0000_0000;
            hresp_r <= 1'b0;
        end
        else if (acc)
        begin
            hrdata_r <= write_r ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
    end

    // software control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            modem_ctrl_r <= `RST_MODEM_CTRL;
            extra_ctrl_r <= `RST_EXTRA_CTRL;
            fifo_en_r <= 1'b0;
            irq_mask_r <= `RST_IRQ_MASK;
        end
        else
        begin
            // writes at the modem status address land here
            if (wr_extra)
            begin
                extra_ctrl_r <= wbyte;
            end
            if (wr_mctrl)
            begin
                modem_ctrl_r <= wbyte[`MC_WIDTH-1:0];
            end
            if (wr_fctrl)
            begin
                fifo_en_r <= wbyte[`FC_ENABLE];
            end
            if (wr_imask)
            begin
                irq_mask_r <= wbyte[`IRQ_WIDTH-1:0];
            end
        end
    end

    // sticky interrupt status, set beats write-one clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status_r <= '0;
            irq_r <= 1'b0;
        end
        else if (ce)
        begin
            irq_status_r <= irq_status_nxt;
            irq_r <= |(irq_status_nxt & irq_mask_r);
        end
    end

    // receive pointers; fifo_control write flushes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else if (flush)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else if (ce)
        begin
            // stored characters never touched by an overrun
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (`RXF_AW+1)'(push) - (`RXF_AW+1)'(pop);
        end
    end

    // overrun flag: set on full arrival, cleared by line status read, set wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            overrun_r <= 1'b0;
        end
        else if (over)
        begin
            overrun_r <= 1'b1;
        end
        else if (rd_line)
        begin
            overrun_r <= 1'b0;
        end
    end

    // two-stage synchroniser of the modem pins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta_r <= `RST_MODEM_PINS;
            pin_sync_r <= `RST_MODEM_PINS;
            live_prev_r <= 4'h0;
        end
        else if (ce)
        begin
            pin_meta_r <= {cd_n, ri_n, dsr_n, cts_n};
            pin_sync_r <= pin_meta_r;
            live_prev_r <= live;
        end
    end

    // change detection on the live bits
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_delta
            if (gi == `MS_DELTA_RI)
            begin : g_ring
                // ring pin low to high is the live bit falling
                assign delta_set[gi] = live_prev_r[gi] & ~live[gi];
            end
            else
            begin : g_any
                assign delta_set[gi] = live_prev_r[gi] ^ live[gi];
            end

            // change flag, set wins over read clear
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    delta_r[gi] <= 1'b0;
                end
                else if (ce & delta_set[gi])
                begin
                    delta_r[gi] <= 1'b1;
                end
                else if (rd_modem)
                begin
                    delta_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // outputs straight from registers
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign modem_ctrl = modem_ctrl_r;
    assign extra_ctrl = extra_ctrl_r;
    assign irq = irq_r;

endmodule

`default_nettype wire

// >>> src/uart_status_cfg.svh
// offsets, bit positions, reset values and sizes for the uart status block
`ifndef UART_STATUS_CFG_SVH
`define UART_STATUS_CFG_SVH

// register byte offsets (low eight address bits)
`define OFF_RX_DATA      8'h00
`define OFF_LINE_STATUS  8'h04
`define OFF_MODEM_STATUS 8'h08
`define OFF_MODEM_CTRL   8'h0C
`define OFF_FIFO_CTRL    8'h10
`define OFF_IRQ_STATUS   8'h14
`define OFF_IRQ_MASK     8'h18

// line_status bit positions
`define LS_DATA_READY    0
`define LS_OVERRUN       1
`define LS_PARITY        2

// modem_input_status: live bits 7:4, change flags 3:0
`define MS_LIVE_LSB      4
`define MS_DELTA_RI      2

// modem_output_control bit positions
`define MC_DTR           0
`define MC_RTS           1
`define MC_OUT_ONE       2
`define MC_OUT_TWO       3
`define MC_LOOP          4
`define MC_WIDTH         5

// fifo_control bit positions
`define FC_ENABLE        0

// interrupt status / mask bit positions
`define IRQ_MODEM        0
`define IRQ_OVERRUN      1
`define IRQ_PARITY       2
`define IRQ_RX_READY     3
`define IRQ_WIDTH        4

// reset values
`define RST_MODEM_CTRL   5'h00
`define RST_EXTRA_CTRL   8'h00
`define RST_IRQ_MASK     4'h0
`define RST_MODEM_PINS   4'hF

// receive fifo size
`define RXF_DEPTH        16
`define RXF_AW           4

`endif

// >>> src/uart_status_pkg.sv
// shared types of the uart status block
package uart_status_pkg;

    // bus slave phase
    typedef enum {ST_ADDR, ST_DATA} bus_state_t;

    // one stored received character with its parity verdict
    typedef struct packed {
        logic parity_bad;
        logic [7:0] data;
    } rx_entry_t;

endpackage

// >>> tb/modem_peer.sv
// modem side model driving the active-low modem control inputs
`timescale 1ns/100ps
`default_nettype none
module modem_peer
(
    // wanted line levels
    input wire logic [3:0] lvl_n,
    // modem lines, active low
    output wire logic cd_n,
    output wire logic ri_n,
    output wire logic dsr_n,
    output wire logic cts_n
);
    logic [3:0] line_n = 4'hF; // lines idle inactive
    // lines move off the clock edge, so the block must synchronise them
    always @(lvl_n)
        line_n <= #7 lvl_n;
    assign {cd_n, ri_n, dsr_n, cts_n} = line_n;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the uart line and modem status block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rx_valid = 1'b0;
    logic rx_parity_bad = 1'b0;
    logic ce = 1'b1; // clock enable, dropped once to freeze the block
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0] rx_data = 8'h00;
    logic [3:0] lvl_n = 4'hF; // wanted modem levels
    wire [31:0] hrdata;
    wire hreadyout, hresp, cd_n, ri_n, dsr_n, cts_n, irq;
    wire [4:0] modem_ctrl;
    wire [7:0] extra_ctrl;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 42707;
    int j;
    logic [31:0] r; // last read data
    logic [3:0] f, m;
    logic [7:0] d;
    logic p;
    logic [7:0] q_d[$]; // expected stored characters
    logic q_p[$]; // their parity verdicts

    always #10 hclk = ~hclk;

    uart_line_modem_status dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_parity_bad(rx_parity_bad), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n),
        .modem_ctrl(modem_ctrl), .extra_ctrl(extra_ctrl), .irq(irq));
    modem_peer peer (.lvl_n(lvl_n), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n));

    // counts, verdict, end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // compare and report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // bounded wait for hready sampled high
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, hreadyout, 1'b1);
            test_done();
        end
    endtask

    // one single-word transfer; read data lands in r
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        r = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(r, exp);
    endtask

    // offer one received character for a single cycle
    task automatic push(input logic [7:0] dv, input logic pv);
        rx_valid <= 1'b1;
        rx_data <= dv;
        rx_parity_bad <= pv;
        @(posedge hclk);
        rx_valid <= 1'b0;
        rx_data <= ~dv;
        @(posedge hclk);
    endtask

    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(modem_ctrl, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        $display("test reset done");
        // modem toggles, ring both ways first
        bus(1'b1, 8'h18, 32'h0000_0001);
        rd(8'h18, 32'h0000_0001);
        for (int k = 0; k < 10; k++)
        begin
            j = (k < 2) ? 2 : $unsigned($random(seed)) % 4;
            lvl_n[j] <= ~lvl_n[j];
            repeat (8) @(posedge hclk);
            f = (j != 2 || lvl_n[2]) ? 4'h1 << j : 4'h0;
            check(irq, f != 4'h0);
            rd(8'h08, {24'h00_0000, ~lvl_n, f});
            rd(8'h08, {24'h00_0000, ~lvl_n, 4'h0});
            bus(1'b1, 8'h14, 32'h0000_000F);
            repeat (2) @(posedge hclk);
            check(irq, 1'b0);
        end
        $display("test modem done");
        // loopback mapping of control bits
        for (int k = 0; k < 4; k++)
        begin
            m = $random(seed);
            bus(1'b1, 8'h0C, {27'h000_0000, 1'b1, m});
            repeat (6) @(posedge hclk);
            check(modem_ctrl, {1'b1, m});
            bus(1'b0, 8'h08, 32'h0000_0000);
            check(r[7:4], {m[3], m[2], m[0], m[1]});
        end
        bus(1'b1, 8'h0C, 32'h0000_0000);
        repeat (6) @(posedge hclk);
        bus(1'b0, 8'h08, 32'h0000_0000);
        d = $random(seed);
        bus(1'b1, 8'h08, {24'h00_0000, d});
        check(extra_ctrl, d);
        rd(8'h08, {24'h00_0000, ~lvl_n, 4'h0});
        rd(8'h20, 32'h0000_0000);
        $display("test loopback done");
        // single holding register: parity, overrun, drop; every event masked out
        bus(1'b1, 8'h10, 32'h0000_0000);
        bus(1'b1, 8'h18, 32'h0000_0000);
        bus(1'b1, 8'h14, 32'h0000_000F);
        push(d, 1'b1);
        rd(8'h04, 32'h0000_0005);
        rd(8'h14, 32'h0000_000C);
        push(~d, 1'b0);
        rd(8'h04, 32'h0000_0007);
        rd(8'h14, 32'h0000_000E);
        check(irq, 1'b0);
        rd(8'h00, {24'h00_0000, d});
        rd(8'h04, 32'h0000_0000);
        // frozen block ignores an offered character
        ce <= 1'b0;
        push(d, 1'b1);
        ce <= 1'b1;
        rd(8'h04, 32'h0000_0000);
        // fifo filled past full, then drained in order
        bus(1'b1, 8'h10, 32'h0000_0001);
        rd(8'h10, 32'h0000_0001);
        for (int k = 0; k < 17; k++)
        begin
            d = $random(seed);
            p = $random(seed);
            if (k < 16)
            begin
                q_d.push_back(d);
                q_p.push_back(p);
            end
            push(d, p);
        end
        rd(8'h04, {29'h0000_0000, q_p[0], 2'b11});
        while (q_d.size() > 0)
        begin
            rd(8'h04, {29'h0000_0000, q_p[0], 2'b01});
            rd(8'h00, {24'h00_0000, q_d.pop_front()});
            void'(q_p.pop_front());
        end
        rd(8'h04, 32'h0000_0000);
        $display("test receive done");
        test_done();
    end
endmodule

bind uart_line_modem_status uart_status_asserts chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n),
    .modem_ctrl(modem_ctrl), .extra_ctrl(extra_ctrl), .irq(irq));
`default_nettype wire

// >>> tb/uart_status_asserts.sv
// property checker for the uart line and modem status block
`timescale 1ns/100ps
`default_nettype none
module uart_status_asserts
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // modem side
    input wire logic cd_n,
    input wire logic ri_n,
    input wire logic dsr_n,
    input wire logic cts_n,
    input wire logic [4:0] modem_ctrl,
    input wire logic [7:0] extra_ctrl,
    input wire logic irq
);
    logic pend_r; // transfer in flight
    logic wr_r; // its direction
    logic [7:0] adr_r; // its offset
    logic [3:0] mask_r; // shadow of the interrupt mask
    wire take = ce && hsel && hready && htrans[1] && hreadyout; // address accepted
    wire done = pend_r && hreadyout; // data phase ends
    wire rd_at = done && !wr_r; // read data valid now
    wire [3:0] pins_n = {cd_n, ri_n, dsr_n, cts_n}; // live order of the status bits

    // track the transfer between address and data edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pend_r <= 1'b0;
        else if (take)
            pend_r <= 1'b1;
        else if (done)
            pend_r <= 1'b0;
    end

    // latch offset and direction; shadow mask writes at the capture edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_r <= 1'b0;
            adr_r <= 8'h00;
            mask_r <= 4'h0;
        end
        else
        begin
            if (take)
                wr_r <= hwrite;
            if (take)
                adr_r <= haddr[7:0];
            if (pend_r && !hreadyout && wr_r && adr_r == 8'h18)
                mask_r <= hwdata[3:0];
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("wait state count wrong");
    a_read_upper: assert property (rd_at |-> hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (rd_at && adr_r == 8'h20 |-> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_line_spare: assert property (rd_at && adr_r == 8'h04 |-> hrdata[7:3] == 5'h00)
        else $error("line status spare bits set");
    a_loop_bits: assert property (rd_at && adr_r == 8'h08 && modem_ctrl[4] && modem_ctrl == $past(modem_ctrl, 4)
        |-> hrdata[7:4] == {modem_ctrl[3], modem_ctrl[2], modem_ctrl[0], modem_ctrl[1]})
        else $error("loopback status bits wrong");
    a_live_bits: assert property (rd_at && adr_r == 8'h08 && !modem_ctrl[4] && modem_ctrl == $past(modem_ctrl, 5)
        && pins_n == $past(pins_n, 5) |-> hrdata[7:4] == ~pins_n)
        else $error("live status bits wrong");
    a_ctrl_write: assert property (done && wr_r && adr_r == 8'h0C |-> modem_ctrl == hwdata[4:0])
        else $error("modem control write lost");
    a_extra_write: assert property (done && wr_r && adr_r == 8'h08 |-> extra_ctrl == hwdata[7:0])
        else $error("extra control write lost");
    a_irq_masked: assert property (mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !irq)
        else $error("interrupt while masked");
    a_irq_raise: assert property (mask_r[0] && !modem_ctrl[4] && cts_n != $past(cts_n) |-> ##[2:6] irq)
        else $error("no interrupt on modem change");
endmodule
`default_nettype wire
